/* File: src/cgsr_consts.svh */
// Register offsets, field positions, reset values and frame counts of the channel register bank
`ifndef CGSR_CONSTS_SVH
`define CGSR_CONSTS_SVH

// Register offsets
`define CGSR_ADDR_STATUS 8'h00
`define CGSR_ADDR_GENERAL 8'h01
`define CGSR_ADDR_TIMING 8'h04
`define CGSR_ADDR_FUNC 8'h05
`define CGSR_ADDR_DIR 8'h07
`define CGSR_ADDR_DRIVER 8'h09
`define CGSR_ADDR_LEVEL 8'h0B
`define CGSR_ADDR_READBACK 8'h0D
`define CGSR_ADDR_SCAN 8'h10
`define CGSR_ADDR_MANUAL 8'h11
`define CGSR_ADDR_MASK 8'h12

// Field positions
`define CGSR_BIT_ACTIVE 6
`define CGSR_BIT_FORCE 2
`define CGSR_BIT_SWRST 0
`define CGSR_BIT_OSC 4
`define CGSR_BIT_GO 4

// Reset values
`define CGSR_RST_BYTE 8'h00
`define CGSR_RST_DIV 4'h4
`define CGSR_RST_CODE 4'h0

// Serial frame: command byte, address byte, data byte
`define CGSR_OP_WRITE 8'h08
`define CGSR_OP_READ 8'h10
`define CGSR_CNT_CMD 5'h08
`define CGSR_CNT_ADDR 5'h10
`define CGSR_CNT_DATA 5'h18
`define CGSR_CNT_LAST 5'h17

`endif

/* File: src/cgsr_pkg.sv */
// Types shared by the channel register bank and its serial front end
package cgsr_pkg;

  typedef enum logic [1:0] {
    CGSR_MANUAL = 2'h0,
    CGSR_AUTO = 2'h1,
    CGSR_OTF = 2'h2,
    CGSR_RSVD = 2'h3
  } cgsr_method_t;

  typedef enum logic {
    CGSR_SEQ_IDLE = 1'h0,
    CGSR_SEQ_RUN = 1'h1
  } cgsr_seq_state_t;

endpackage : cgsr_pkg

/* File: src/cgsr_spi_frame.sv */
// Serial frame engine: turns SPI frames into register read and write strobes
`timescale 1ns/100ps
`include "cgsr_consts.svh"

module cgsr_spi_frame (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  import cgsr_pkg::*;

  logic sclk_s1, sclk_s2, sclk_s3;
  logic csn_s1, csn_s2;
  logic mosi_s1, mosi_s2;
  logic [4:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] cmd;
  logic load_pend;
  logic sclk_rise, sclk_fall;
  logic [7:0] next_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken from the second and third stage only
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end
    else
    begin
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      csn_s1 <= csn_i;
      csn_s2 <= csn_s1;
      mosi_s1 <= mosi_i;
      mosi_s2 <= mosi_s1;
    end
  end

  // Mode 0 only: sample on rising edge, shift out on falling edge
  assign sclk_rise = sclk_s2 & ~sclk_s3 & ~csn_s2;
  assign sclk_fall = ~sclk_s2 & sclk_s3 & ~csn_s2;
  assign next_byte = {shift_in[6:0], mosi_s2};

  //////////////////////////////////////////////////////////////////////////////
  // Incoming bits, command and address capture, strobes
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      cmd <= 8'h00;
      reg_addr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
    end
    else
    begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      if (csn_s2)
      begin
        bit_cnt <= 5'h00;
        cmd <= 8'h00;
      end
      else if (sclk_rise)
      begin
        shift_in <= next_byte;
        // Extra clocks past the data byte are ignored
        if (bit_cnt != `CGSR_CNT_DATA)
          bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt + 5'h01 == `CGSR_CNT_CMD)
          cmd <= next_byte;
        if (bit_cnt + 5'h01 == `CGSR_CNT_ADDR)
        begin
          reg_addr_o <= next_byte;
          reg_rd_o <= (cmd == `CGSR_OP_READ);
        end
        if (bit_cnt + 5'h01 == `CGSR_CNT_DATA)
        begin
          reg_wdata_o <= next_byte;
          reg_wr_o <= (cmd == `CGSR_OP_WRITE);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data out; loaded well before the first data falling edge if SCLK is slow
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      load_pend <= 1'b0;
      shift_out <= 8'h00;
      miso_o <= 1'b0;
    end
    else
    begin
      load_pend <= reg_rd_o;
      if (csn_s2)
      begin
        shift_out <= 8'h00;
        miso_o <= 1'b0;
      end
      else if (load_pend)
      begin
        shift_out <= reg_rdata_i;
        miso_o <= reg_rdata_i[7];
      end
      else if (sclk_fall && bit_cnt > `CGSR_CNT_ADDR && bit_cnt <= `CGSR_CNT_LAST)
      begin
        shift_out <= {shift_out[6:0], 1'b0};
        miso_o <= shift_out[6];
      end
    end
  end

endmodule : cgsr_spi_frame

/* File: src/cgsr_regs.sv */
// Channel configuration register bank with pin control and channel sequencer
`timescale 1ns/100ps
`include "cgsr_consts.svh"

// Overview of operation
// - Oscillator choice bit 0 picks high-speed, 1 picks low-power timing source.
// - Four-bit sample-rate divider, reset 0100, steers averaging sample speed.
// - Function-select bit 0 makes channel analog, 1 makes it general I/O.
// - For general I/O, direction bit 0 is input, 1 is output.
// - Driver-type bit 0 gives open-drain output, 1 gives push-pull.
// - Output-level bit sets driven logic value; resets to all zeros.
// - Read-only byte reports present logic level of every pin.
// - Scan method: 00 manual, 01 automatic, 10 on-the-fly, 11 reserved.
// - In automatic method scan-go 1 starts ascending scan, 0 stops it.
// - Manual method converts channel code 0 to 7; codes 1xxx reserved.
// - Reset clears channel, I/O and scan registers to zero.
// - Force-all-analog makes every channel analog regardless of other settings.
// - Scan-active status reads 1 while a sequence runs, else 0.
// - Automatic scan includes only channels whose mask bit is 1.
module cgsr_regs (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic spi_sclk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe_o,
  output logic [7:0] analog_enable_o,
  output logic timing_oscillator_choice_o,
  output logic [3:0] sample_rate_divider_o,
  output cgsr_pkg::cgsr_method_t scan_method_o,
  input wire logic conv_done_i,
  output logic [2:0] conv_channel_o,
  output logic conv_channel_valid_o
);
  import cgsr_pkg::*;

  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic soft_rst;
  logic force_all_analog;
  logic [7:0] channel_function_select, io_direction, output_driver_type, output_level;
  logic [7:0] gpio_s1, input_level_readback;
  logic scan_go;
  cgsr_method_t scan_method;
  logic [3:0] manual_channel_code;
  logic [7:0] scan_channel_mask;
  cgsr_seq_state_t seq_state;
  logic [2:0] scan_ptr;
  logic scan_active, scan_run;
  logic [7:0] analog_map, drive_en;
  logic [2:0] next_channel;
  logic next_valid;

  // Lowest set mask bit at or after cur (incl) or strictly after cur, wrapping
  function automatic logic [2:0] cgsr_next_ch(input logic [7:0] mask, input logic [2:0] cur,
                                              input logic incl);
    logic [2:0] idx;
    logic [2:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      idx = cur + 3'(k) + {2'b00, ~incl};
      if (!found && mask[idx])
      begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction : cgsr_next_ch

  //////////////////////////////////////////////////////////////////////////////
  // Serial front end
  cgsr_spi_frame u_frame (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .sclk_i(spi_sclk_i),
    .csn_i(spi_csn_i),
    .mosi_i(spi_mosi_i),
    .miso_o(spi_miso_o),
    .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata)
  );

  // Software reset acts for one cycle and wins over every other write
  assign soft_rst = reg_wr && reg_addr == `CGSR_ADDR_GENERAL && reg_wdata[`CGSR_BIT_SWRST];

  //////////////////////////////////////////////////////////////////////////////
  // Timing source and general control
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      timing_oscillator_choice_o <= 1'b0;
      sample_rate_divider_o <= `CGSR_RST_DIV;
      force_all_analog <= 1'b0;
    end
    // Software reset is a synchronous clear, kept out of the async branch
    else if (soft_rst)
    begin
      timing_oscillator_choice_o <= 1'b0;
      sample_rate_divider_o <= `CGSR_RST_DIV;
      force_all_analog <= 1'b0;
    end
    else if (reg_wr && reg_addr == `CGSR_ADDR_TIMING)
    begin
      timing_oscillator_choice_o <= reg_wdata[`CGSR_BIT_OSC];
      sample_rate_divider_o <= reg_wdata[3:0];
    end
    else if (reg_wr && reg_addr == `CGSR_ADDR_GENERAL)
      force_all_analog <= reg_wdata[`CGSR_BIT_FORCE];
  end

  // Channel and I/O configuration
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      channel_function_select <= `CGSR_RST_BYTE;
      io_direction <= `CGSR_RST_BYTE;
      output_driver_type <= `CGSR_RST_BYTE;
      output_level <= `CGSR_RST_BYTE;
    end
    else if (soft_rst)
    begin
      channel_function_select <= `CGSR_RST_BYTE;
      io_direction <= `CGSR_RST_BYTE;
      output_driver_type <= `CGSR_RST_BYTE;
      output_level <= `CGSR_RST_BYTE;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `CGSR_ADDR_FUNC: channel_function_select <= reg_wdata;
        `CGSR_ADDR_DIR: io_direction <= reg_wdata;
        `CGSR_ADDR_DRIVER: output_driver_type <= reg_wdata;
        `CGSR_ADDR_LEVEL: output_level <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Scan configuration; a reserved method code is stored but runs nothing
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scan_method <= CGSR_MANUAL;
      scan_go <= 1'b0;
      manual_channel_code <= `CGSR_RST_CODE;
      scan_channel_mask <= `CGSR_RST_BYTE;
    end
    else if (soft_rst)
    begin
      scan_method <= CGSR_MANUAL;
      scan_go <= 1'b0;
      manual_channel_code <= `CGSR_RST_CODE;
      scan_channel_mask <= `CGSR_RST_BYTE;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `CGSR_ADDR_SCAN:
        begin
          scan_method <= cgsr_method_t'(reg_wdata[1:0]);
          scan_go <= reg_wdata[`CGSR_BIT_GO];
        end
        `CGSR_ADDR_MANUAL: manual_channel_code <= reg_wdata[3:0];
        `CGSR_ADDR_MASK: scan_channel_mask <= reg_wdata;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins: synchronise inputs, drive only general-I/O outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gpio_s1 <= 8'h00;
      input_level_readback <= 8'h00;
    end
    else
    begin
      gpio_s1 <= gpio_i;
      input_level_readback <= gpio_s1;
    end
  end

  assign analog_map = channel_function_select == 8'h00 || force_all_analog ?
                      8'hFF : ~channel_function_select;
  assign drive_en = channel_function_select & io_direction & ~{8{force_all_analog}};

  // Open-drain high is released to the external pullup, never driven
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      analog_enable_o <= 8'hFF;
      gpio_oe_o <= 8'h00;
      gpio_o <= 8'h00;
    end
    else
    begin
      analog_enable_o <= analog_map;
      gpio_oe_o <= drive_en & (output_driver_type | ~output_level);
      gpio_o <= drive_en & output_driver_type & output_level;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Automatic scan sequencer
  assign scan_run = scan_method == CGSR_AUTO && scan_go;
  assign scan_active = seq_state == CGSR_SEQ_RUN;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      seq_state <= CGSR_SEQ_IDLE;
      scan_ptr <= 3'h0;
    end
    else if (soft_rst)
    begin
      seq_state <= CGSR_SEQ_IDLE;
      scan_ptr <= 3'h0;
    end
    else
    begin
      unique case (seq_state)
        CGSR_SEQ_IDLE:
          if (scan_run)
          begin
            seq_state <= CGSR_SEQ_RUN;
            scan_ptr <= cgsr_next_ch(scan_channel_mask, 3'h0, 1'b1);
          end
        CGSR_SEQ_RUN:
          if (!scan_run)
            seq_state <= CGSR_SEQ_IDLE;
          else if (!scan_channel_mask[scan_ptr])
            scan_ptr <= cgsr_next_ch(scan_channel_mask, scan_ptr, 1'b1);
          else if (conv_done_i)
            scan_ptr <= cgsr_next_ch(scan_channel_mask, scan_ptr, 1'b0);
      endcase
    end
  end

  // Channel handed to the converter; a general-I/O channel never reads as valid
  always_comb
  begin
    next_channel = manual_channel_code[2:0];
    next_valid = 1'b0;
    unique case (scan_method)
      CGSR_MANUAL: next_valid = ~manual_channel_code[3]
                                & analog_map[manual_channel_code[2:0]];
      CGSR_AUTO:
      begin
        next_channel = scan_ptr;
        next_valid = scan_active && scan_channel_mask[scan_ptr] && analog_map[scan_ptr];
      end
      CGSR_OTF: next_valid = 1'b0;
      CGSR_RSVD: next_valid = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      conv_channel_o <= 3'h0;
      conv_channel_valid_o <= 1'b0;
      scan_method_o <= CGSR_MANUAL;
    end
    else
    begin
      conv_channel_o <= next_channel;
      conv_channel_valid_o <= next_valid;
      scan_method_o <= scan_method;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, taken on the read strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `CGSR_ADDR_STATUS: reg_rdata <= {1'b0, scan_active, 6'h00};
        `CGSR_ADDR_GENERAL: reg_rdata <= {5'h00, force_all_analog, 2'h0};
        `CGSR_ADDR_TIMING: reg_rdata <= {3'h0, timing_oscillator_choice_o,
                                         sample_rate_divider_o};
        `CGSR_ADDR_FUNC: reg_rdata <= channel_function_select;
        `CGSR_ADDR_DIR: reg_rdata <= io_direction;
        `CGSR_ADDR_DRIVER: reg_rdata <= output_driver_type;
        `CGSR_ADDR_LEVEL: reg_rdata <= output_level;
        `CGSR_ADDR_READBACK: reg_rdata <= input_level_readback;
        `CGSR_ADDR_SCAN: reg_rdata <= {3'h0, scan_go, 2'h0, scan_method};
        `CGSR_ADDR_MANUAL: reg_rdata <= {4'h0, manual_channel_code};
        `CGSR_ADDR_MASK: reg_rdata <= scan_channel_mask;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_osc_write;
    reg_wr && reg_addr == `CGSR_ADDR_TIMING |-> ##1
      timing_oscillator_choice_o == $past(reg_wdata[`CGSR_BIT_OSC]);
  endproperty
  a_osc_write: assert property (p_osc_write) else $error("oscillator choice not taken");

  property p_div_reset;
    soft_rst |=> sample_rate_divider_o == `CGSR_RST_DIV;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not back to default");

  property p_analog_map;
    ##1 (!force_all_analog && $past(!force_all_analog)) |->
      (analog_enable_o & $past(channel_function_select)) == 8'h00
      || $past(channel_function_select) == 8'h00;
  endproperty
  a_analog_map: assert property (p_analog_map) else $error("I/O channel shown analog");

  property p_dir_out;
    1'b1 |=> (gpio_oe_o & $past(output_driver_type))
      == $past(channel_function_select & io_direction & output_driver_type
               & ~{8{force_all_analog}});
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("push-pull output not enabled");

  property p_open_drain;
    1'b1 |=> (gpio_o & ~$past(output_driver_type)) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");

  property p_level;
    1'b1 |=> ((gpio_o ^ $past(output_level)) & gpio_oe_o & $past(output_driver_type)) == 8'h00;
  endproperty
  a_level: assert property (p_level) else $error("driven level wrong");

  property p_readback;
    ##2 1'b1 |-> input_level_readback == $past(gpio_i, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback not pin level");

  property p_reserved_method;
    scan_method == CGSR_RSVD && !soft_rst |=> !conv_channel_valid_o;
  endproperty
  a_reserved_method: assert property (p_reserved_method) else $error("reserved runs");

  property p_scan_start;
    scan_run && !scan_active && !soft_rst |=> scan_active;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan did not start");

  property p_manual_chan;
    scan_method == CGSR_MANUAL && !soft_rst |=>
      conv_channel_o == $past(manual_channel_code[2:0])
      && (!$past(manual_channel_code[3]) || !conv_channel_valid_o);
  endproperty
  a_manual_chan: assert property (p_manual_chan) else $error("manual channel wrong");

  property p_soft_clear;
    soft_rst |=> channel_function_select == 8'h00 && scan_method == CGSR_MANUAL
      && manual_channel_code == 4'h0 && !scan_active;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("registers not cleared");

  property p_force;
    force_all_analog |=> analog_enable_o == 8'hFF && gpio_oe_o == 8'h00;
  endproperty
  a_force: assert property (p_force) else $error("force-all-analog ignored");

  property p_scan_stop;
    !scan_run |=> !scan_active;
  endproperty
  a_scan_stop: assert property (p_scan_stop) else $error("scan still active");

  property p_mask;
    scan_active && $past(scan_active) && $stable(scan_channel_mask)
      && scan_channel_mask != 8'h00 |-> scan_channel_mask[scan_ptr];
  endproperty
  a_mask: assert property (p_mask) else $error("masked channel in scan");

  property p_no_drive;
    1'b1 |=> (gpio_oe_o & ~$past(drive_en)) == 8'h00;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven while not output");

  c_scan_run: cover property (!scan_active ##1 scan_active ##[1:50] conv_done_i);
  c_push_pull: cover property (gpio_oe_o != 8'h00 && gpio_o != 8'h00);
  c_manual_valid: cover property (scan_method == CGSR_MANUAL && conv_channel_valid_o);
  c_soft_reset: cover property (soft_rst);

endmodule : cgsr_regs

/* File: testbench/cgsr_spi_host.sv */
// SPI host model that frames register reads and writes in mode 0
`timescale 1ns/100ps

module cgsr_spi_host (
  input wire logic ref_clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic csn_o,
  output logic mosi_o
);
  // Idle bus: clock low and deselected
  initial
  begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Wait reference edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // One 24-bit frame, MSB first; 8-cycle half periods clear the pin synchronisers
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [23:0] sh;
    sh = {cmd, addr, wd};
    rd = 8'h00;
    tick(1);
    csn_o = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      mosi_o = sh[i];
      tick(8);
      // Read data is settled at the end of the low phase
      if (i < 8)
        rd[i] = miso_i;
      sclk_o = 1'b1;
      tick(8);
      sclk_o = 1'b0;
    end
    tick(4);
    csn_o = 1'b1;
    // Deselected data line must not keep showing the last bit
    mosi_o = ~mosi_o;
    tick(6);
  endtask : xfer
endmodule : cgsr_spi_host

/* File: testbench/channel_gpio_sequencer_regs_test.sv */
// Self-checking bench for the channel register bank
`timescale 1ns/100ps
`include "cgsr_consts.svh"

module channel_gpio_sequencer_regs_test;
  import cgsr_pkg::*;
  logic ref_clk_i, resetn_i, sclk, csn, mosi, miso, osc, conv_done, chv;
  logic [7:0] gpio_i, gpio_o, gpio_oe, ana, ext, r, msk;
  logic [3:0] div;
  logic [2:0] ch;
  cgsr_pkg::cgsr_method_t meth;
  logic [7:0] m [0:255];
  int n_errors, samples_checked, p;

  cgsr_regs uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
    .spi_csn_i(csn), .spi_mosi_i(mosi), .spi_miso_o(miso), .gpio_i(gpio_i),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .analog_enable_o(ana),
    .timing_oscillator_choice_o(osc), .sample_rate_divider_o(div), .scan_method_o(meth),
    .conv_done_i(conv_done), .conv_channel_o(ch), .conv_channel_valid_o(chv));
  cgsr_spi_host host (.ref_clk_i(ref_clk_i), .miso_i(miso), .sclk_o(sclk), .csn_o(csn),
    .mosi_o(mosi));

  // Pin wire: driven value where enabled, otherwise the outside level
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext);

  // 125 MHz reference clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Model and check helpers
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic model_reset();
    foreach (m[i])
      m[i] = 8'h00;
    m[4] = `CGSR_RST_DIV;
  endtask : model_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(`CGSR_OP_WRITE, a, d, r);
    m[a] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    host.xfer(`CGSR_OP_READ, a, 8'($urandom), r);
  endtask : rd

  // Expected pin drive: forced-analog wins, open-drain drives only a low level
  function automatic logic [7:0] exp_oe();
    return m[1][2] ? 8'h00 : (m[5] & m[7] & (m[9] | ~m[11]));
  endfunction : exp_oe

  task automatic chk_pins();
    chk(gpio_oe, exp_oe(), "oe");
    chk(gpio_o, exp_oe() & m[9] & m[11], "out");
    chk(ana, m[1][2] ? 8'hFF : ~m[5], "analog");
    chk(8'(osc), 8'(m[4][4]), "osc");
    chk(8'(div), 8'(m[4][3:0]), "div");
  endtask : chk_pins

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #700000;
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    end_of_test();
  end

  // Main sequence
  initial
  begin
    resetn_i = 1'b0;
    conv_done = 1'b0;
    void'($urandom(71));
    ext = 8'($urandom);
    model_reset();
    repeat (4) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    host.tick(4);
    for (int a = 4; a <= 18; a++)
    begin
      if (a inside {4, 5, 7, 9, 11, 16, 17, 18})
      begin
        rd(8'(a));
        chk(r, m[a], "reset value");
      end
    end
    chk_pins();
    chk(8'(chv), 8'h01, "channel 0 valid");
    $display("test reset done");
    // Random register traffic, reserved timing bits read back as zero
    for (int k = 0; k < 20; k++)
    begin
      p = $urandom % 6;
      msk = 8'($urandom);
      msk = (p == 0) ? (msk & 8'h1F) : msk;
      wr(p == 0 ? 8'h04 : (p == 5 ? 8'h12 : 8'(5 + 2 * (p - 1))), msk);
      rd(p == 0 ? 8'h04 : (p == 5 ? 8'h12 : 8'(5 + 2 * (p - 1))));
      chk(r, msk, "readback");
      chk_pins();
      // Released open-drain outputs sit at the external pullup level
      ext = 8'($urandom) | (m[1][2] ? 8'h00 : m[5] & m[7] & ~m[9]);
      wr(8'h0D, 8'($urandom));
      m[13] = 8'h00;
      rd(8'h0D);
      chk(r, (exp_oe() & m[9] & m[11]) | (~exp_oe() & ext), "pin level");
    end
    $display("test registers done");
    wr(8'h01, 8'h04);
    chk_pins();
    wr(8'h01, 8'h00);
    chk_pins();
    $display("test force done");
    // Manual channel codes, reserved codes and GPIO channels give no valid pick
    wr(8'h10, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h11, 8'(c));
      chk(8'(ch), 8'(c % 8), "manual channel");
      chk(8'(chv), 8'(c < 8 && !m[5][c % 8]), "manual valid");
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h10, 8'(k));
      chk(8'(meth), 8'(k), "method");
    end
    $display("test manual done");
    // Auto scan over a random mask, ascending with wrap
    wr(8'h05, 8'h00);
    msk = 8'($urandom) | 8'h80;
    wr(8'h12, msk);
    wr(8'h10, 8'h11);
    rd(8'h00);
    chk(8'(r[6]), 8'h01, "scan active");
    p = 0;
    while (!msk[p])
      p++;
    for (int k = 0; k < 12; k++)
    begin
      chk(8'(ch), 8'(p), "scan channel");
      chk(8'(chv), 8'h01, "scan valid");
      conv_done = 1'b1;
      host.tick(1);
      conv_done = 1'b0;
      host.tick(3);
      p = (p + 1) % 8;
      while (!msk[p])
        p = (p + 1) % 8;
    end
    wr(8'h10, 8'h01);
    rd(8'h00);
    chk(8'(r[6]), 8'h00, "scan stopped");
    $display("test auto done");
    // Software reset returns everything to defaults
    wr(8'h07, 8'hFF);
    wr(8'h01, 8'h01);
    model_reset();
    chk_pins();
    rd(8'h10);
    chk(r, 8'h00, "scan after reset");
    rd(8'h07);
    chk(r, 8'h00, "dir after reset");
    $display("test soft reset done");
    end_of_test();
  end
endmodule : channel_gpio_sequencer_regs_test
